// >>> core/addr_mod_pkg.sv
// package: bit times, phases, opcodes, register map and reset values for the address modifier
package addr_mod_pkg;

    // bit time codes: Tk is k+1, the final bit time is zero, counting down
    localparam logic [4:0] BT_T24 = 5'h19;
    localparam logic [4:0] BT_T23 = 5'h18;
    localparam logic [4:0] BT_T10 = 5'h0B;
    localparam logic [4:0] BT_T9  = 5'h0A;
    localparam logic [4:0] BT_T0  = 5'h01;
    localparam logic [4:0] BT_TP  = 5'h00;

    // phase counter values used here
    localparam logic [2:0] PH0 = 3'h0;
    localparam logic [2:0] PH1 = 3'h1;
    localparam logic [2:0] PH7 = 3'h7;

    // opcodes (octal 20, 01, 41, 43)
    localparam logic [5:0] OP_NOP = 6'h10;
    localparam logic [5:0] OP_BRU = 6'h01;
    localparam logic [5:0] OP_BRX = 6'h21;
    localparam logic [5:0] OP_BRM = 6'h23;

    // register byte offsets
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_PC     = 5'h08;
    localparam logic [4:0] OFF_ADDR   = 5'h0C;
    localparam logic [4:0] OFF_INSTR  = 5'h10;

    // status field positions
    localparam int ST_PHASE_LSB = 0;
    localparam int ST_INDEX     = 3;
    localparam int ST_INDIRECT  = 4;
    localparam int ST_TRAP      = 5;
    localparam int ST_OVERFLOW  = 6;
    localparam int ST_CARRY     = 7;
    localparam int ST_OP_LSB    = 8;

    // reset values
    localparam logic [2:0]  RST_PHASE = PH0;
    localparam logic [13:0] RST_PC    = 14'h0000;
    localparam logic [23:0] RST_WORD  = 24'h000000;

    // register port request
    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } bus_req_s;

endpackage

// >>> core/serial_address_modifier.sv
// serial effective-address preparation: adder, indexing, indirect chaining and program-operator trap
//
// Behaviour
// - serial full adder, sum is xor, no delay
// - addend takes instruction register low end
// - instruction starts T24, shifts right through adder
// - carry held clear in phase zero unless indexing
// - index flag set at T24, cleared final bit
// - augend is index bits or zero
// - sum written back only T23 to T10
// - branch opcodes shift sum into counter
// - address copied to memory address at T9
// - opcode loaded at T24 unless indirect/trap
// - indirect flag set on indirect bit at T24
// - single-cycle ops ignore indirect bit
// - indirect holds phase, reloads word from memory
// - extra cycle suppresses opcode, clears on no-indirect
// - every indirect cycle may index again
// - trap flag set at T24, cleared next T24
// - trap shifts opcode field into counter
// - seven zeros follow, opcode stays no-op
// - indirect bit at T9, overflow at T0
// - final bit clears memory data, starts write
// - address cleared T10, trap keeps it zero
// - trap goes to phase seven, fetches anew
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps

module serial_address_modifier (
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire addr_mod_pkg::bus_req_s   req,
    output logic [31:0]                   rdata,
    input  wire logic                     timeshare_active,
    input  wire logic                     index_serial,
    input  wire logic                     single_cycle_op,
    input  wire logic                     exec_done,
    input  wire logic                     overflow_set,
    input  wire logic [23:0]              mem_rdata,
    output logic [13:0]                   mem_addr,
    output logic [23:0]                   mem_wdata,
    output logic                          mem_cycle_start,
    output logic [4:0]                    bit_time,
    output logic [2:0]                    phase,
    output logic [5:0]                    op_code,
    output logic                          add_sum
);
    import addr_mod_pkg::*;

    logic [4:0]  bt_r, bt_nxt;
    logic [2:0]  phase_r, phase_nxt;
    logic [0:23] c_r, c_nxt;
    logic [13:0] pc_r, pc_nxt;
    logic [13:0] addr_r, addr_nxt;
    logic [23:0] wdata_r, wdata_nxt;
    logic [6:0]  tgt_r, tgt_nxt;
    logic [5:0]  op_r, op_nxt;
    logic        carry_ff, carry_nxt;
    logic        index_pending, index_nxt;
    logic        indirect_pending, indirect_nxt;
    logic        prog_operator_flag, prog_nxt;
    logic        overflow_flag, overflow_nxt;
    logic        start_r, start_nxt;
    logic        run_r, run_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic        augend_in;
    logic        addend_in;
    logic        sum;
    logic        ph0;
    logic        win;
    logic        shift_c;
    logic        branch_op;
    logic        prog_operator_bit;
    logic        indirect_bit;
    logic        index_bit;

    ////////////////////////////////////////////////////////////////////////////
    // adder and decode

    // sum is pure combinational: no cycle of delay between inputs and sum
    assign ph0               = (phase_r == PH0);
    assign win               = (bt_r <= BT_T23) && (bt_r >= BT_T10);
    assign shift_c           = ph0 && (bt_r != BT_T24) && (bt_r != BT_TP);
    assign prog_operator_bit = c_r[2];
    assign indirect_bit      = c_r[9];
    assign index_bit         = c_r[1];
    assign augend_in         = index_pending ? index_serial : 1'b0;
    assign addend_in         = (ph0 && !timeshare_active) ? c_r[23] : 1'b0;
    assign sum               = augend_in ^ addend_in ^ carry_ff;
    // branch indexing only on a direct, non-trap cycle of a branch opcode
    assign branch_op         = ((op_r == OP_BRU) || (op_r == OP_BRX) || (op_r == OP_BRM))
                               && !indirect_pending && !prog_operator_flag;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    // everything but the bit timer, the overflow latch and the register port idles while a time-share cycle owns memory
    always_comb begin
        bt_nxt        = (bt_r == BT_TP) ? BT_T24 : bt_r - 5'h01;
        phase_nxt     = phase_r;
        c_nxt         = c_r;
        pc_nxt        = pc_r;
        addr_nxt      = addr_r;
        wdata_nxt     = wdata_r;
        tgt_nxt       = tgt_r;
        op_nxt        = op_r;
        carry_nxt     = carry_ff;
        index_nxt     = index_pending;
        indirect_nxt  = indirect_pending;
        prog_nxt      = prog_operator_flag;
        overflow_nxt  = overflow_flag;
        start_nxt     = 1'b0;
        run_nxt       = run_r;
        rdata_nxt     = 32'h00000000;
        if (!timeshare_active) begin
            // carry starts every address sum from zero
            if (ph0) begin
                if (bt_r == BT_T24 || !index_pending) begin
                    carry_nxt = 1'b0;
                end else if (win) begin
                    carry_nxt = (augend_in & addend_in) | (carry_ff & (augend_in ^ addend_in));
                end
            end
            // instruction register shifts right through the adder
            if (shift_c) begin
                c_nxt[1:23] = c_r[0:22];
                if (prog_operator_flag) begin
                    if (win) begin
                        c_nxt[0] = pc_r[0];
                    end else if (bt_r == BT_T9) begin
                        c_nxt[0] = 1'b1;
                    end else if (bt_r == BT_T0) begin
                        c_nxt[0] = overflow_flag;
                    end else begin
                        c_nxt[0] = 1'b0;
                    end
                end else if (win && !branch_op) begin
                    c_nxt[0] = sum;
                end else begin
                    c_nxt[0] = c_r[23];
                end
            end
            // counter takes the indexed branch target or the trap vector
            if (ph0 && win && (branch_op || prog_operator_flag)) begin
                if (prog_operator_flag) begin
                    pc_nxt  = {tgt_r[0], pc_r[13:1]};
                    tgt_nxt = {1'b0, tgt_r[6:1]};
                end else begin
                    pc_nxt  = {sum, pc_r[13:1]};
                end
            end
            // trap word moves into memory data at the T24 after its build
            if (bt_r == BT_T24 && prog_operator_flag) begin
                prog_nxt  = 1'b0;
                wdata_nxt = c_r;
            end
            // instruction start decisions at T24 of phase zero
            if (ph0 && bt_r == BT_T24 && run_r) begin
                if (index_bit) begin
                    index_nxt = 1'b1;
                end
                if (!indirect_pending && !prog_operator_bit) begin
                    op_nxt = c_r[3:8];
                end
                if (!indirect_pending && prog_operator_bit) begin
                    prog_nxt = 1'b1;
                    tgt_nxt  = c_r[2:8];
                    op_nxt   = OP_NOP;
                end
                if (!indirect_pending && indirect_bit && !prog_operator_bit) begin
                    indirect_nxt = 1'b1;
                end else if (indirect_pending && !indirect_bit) begin
                    indirect_nxt = 1'b0;
                end
            end
            if (bt_r == BT_TP) begin
                index_nxt = 1'b0;
            end
            // memory address: cleared at T10, loaded at T9 except in the trap
            if (ph0 && bt_r == BT_T10) begin
                addr_nxt = '0;
            end
            if (ph0 && bt_r == BT_T9 && !prog_operator_flag) begin
                addr_nxt = c_r[0:13];
            end
            if (ph0 && bt_r == BT_T0 && prog_operator_flag) begin
                overflow_nxt = 1'b0;
            end
            // phase sequencing at the final bit time
            if (bt_r == BT_TP) begin
                unique case (phase_r)
                    PH0: begin
                        if (prog_operator_flag) begin
                            phase_nxt = PH7;
                            wdata_nxt = RST_WORD;
                            start_nxt = 1'b1;
                        end else if (indirect_pending && !single_cycle_op) begin
                            c_nxt = mem_rdata;
                        end else begin
                            phase_nxt = PH1;
                        end
                    end
                    PH7: begin
                        phase_nxt = PH0;
                        c_nxt     = mem_rdata;
                    end
                    default: begin
                        if (exec_done) begin
                            phase_nxt = PH0;
                            c_nxt     = mem_rdata;
                        end
                    end
                endcase
            end
            if (phase_r == PH7 && bt_r == BT_T9) begin
                addr_nxt = pc_r;
            end
        end
        // an overflow arriving in the clearing cycle is kept
        if (overflow_set) begin
            overflow_nxt = 1'b1;
        end
        // register writes take priority over the serial datapath
        if (req.we) begin
            unique case (req.addr)
                OFF_CTRL:  run_nxt = req.wdata[0];
                OFF_PC:    pc_nxt  = req.wdata[13:0];
                OFF_INSTR: c_nxt   = req.wdata[23:0];
                default:   ;
            endcase
        end
        if (req.re) begin
            unique case (req.addr)
                OFF_CTRL:   rdata_nxt = {31'h00000000, run_r};
                OFF_STATUS: rdata_nxt = {18'h00000, op_r, carry_ff, overflow_flag, prog_operator_flag,
                                         indirect_pending, index_pending, phase_r};
                OFF_PC:     rdata_nxt = {18'h00000, pc_r};
                OFF_ADDR:   rdata_nxt = {18'h00000, addr_r};
                OFF_INSTR:  rdata_nxt = {8'h00, c_r};
                default:    rdata_nxt = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    // synchronous reset; the machine wakes stopped at T24 of phase zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bt_r               <= BT_T24;
            phase_r            <= RST_PHASE;
            c_r                <= RST_WORD;
            pc_r               <= RST_PC;
            addr_r             <= 14'h0000;
            wdata_r            <= RST_WORD;
            tgt_r              <= 7'h00;
            op_r               <= OP_NOP;
            carry_ff           <= 1'b0;
            index_pending      <= 1'b0;
            indirect_pending   <= 1'b0;
            prog_operator_flag <= 1'b0;
            overflow_flag      <= 1'b0;
            start_r            <= 1'b0;
            run_r              <= 1'b0;
            rdata_r            <= 32'h00000000;
        end else begin
            bt_r               <= bt_nxt;
            phase_r            <= phase_nxt;
            c_r                <= c_nxt;
            pc_r               <= pc_nxt;
            addr_r             <= addr_nxt;
            wdata_r            <= wdata_nxt;
            tgt_r              <= tgt_nxt;
            op_r               <= op_nxt;
            carry_ff           <= carry_nxt;
            index_pending      <= index_nxt;
            indirect_pending   <= indirect_nxt;
            prog_operator_flag <= prog_nxt;
            overflow_flag      <= overflow_nxt;
            start_r            <= start_nxt;
            run_r              <= run_nxt;
            rdata_r            <= rdata_nxt;
        end
    end

    // outputs straight from flip-flops, sum is the live adder output
    assign rdata           = rdata_r;
    assign mem_addr        = addr_r;
    assign mem_wdata       = wdata_r;
    assign mem_cycle_start = start_r;
    assign bit_time        = bt_r;
    assign phase           = phase_r;
    assign op_code         = op_r;
    assign add_sum         = sum;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_trap_tp;
        ph0 && bt_r == BT_TP && prog_operator_flag && !timeshare_active;
    endsequence

    sequence s_trap_start;
        phase_r == PH7 && mem_cycle_start && mem_wdata == 24'h000000;
    endsequence

    a_sum_writeback: assert property (
        shift_c && win && !prog_operator_flag && !branch_op && !timeshare_active && !req.we
        |=> c_r[0] == $past(sum))
        else $error("adder sum not written back into instruction word");

    a_index_set: assert property (
        ph0 && bt_r == BT_T24 && run_r && c_r[1] && !timeshare_active |=> index_pending)
        else $error("index flag not set at T24");

    a_index_clear: assert property (
        bt_r == BT_TP && !timeshare_active |=> !index_pending)
        else $error("index flag not cleared at final bit time");

    a_carry_clear: assert property (
        ph0 && !index_pending && !timeshare_active |=> carry_ff == 1'b0)
        else $error("carry not held clear without indexing");

    a_addr_clear: assert property (
        ph0 && bt_r == BT_T10 && prog_operator_flag && !timeshare_active
        |=> mem_addr == 14'h0000 ##1 mem_addr == 14'h0000)
        else $error("trap did not leave memory address at zero");

    a_addr_load: assert property (
        ph0 && bt_r == BT_T9 && !prog_operator_flag && !timeshare_active |=> mem_addr == $past(c_r[0:13]))
        else $error("address not copied at T9");

    a_op_load: assert property (
        ph0 && bt_r == BT_T24 && run_r && !indirect_pending && !c_r[2] && !timeshare_active
        |=> op_code == $past(c_r[3:8]))
        else $error("opcode not loaded at T24");

    a_op_hold: assert property (
        ph0 && bt_r == BT_T24 && indirect_pending && !timeshare_active |=> $stable(op_code))
        else $error("opcode changed in an indirect cycle");

    a_trap_phase: assert property (s_trap_tp |=> s_trap_start)
        else $error("trap did not enter phase seven with a write");

    a_indirect_hold: assert property (
        ph0 && bt_r == BT_TP && indirect_pending && !prog_operator_flag && !single_cycle_op
        && !timeshare_active && !req.we |=> phase_r == PH0 && c_r == $past(mem_rdata))
        else $error("indirect cycle did not repeat phase zero");

    a_ovf_clear: assert property (
        ph0 && bt_r == BT_T0 && prog_operator_flag && !timeshare_active && !overflow_set
        |=> !overflow_flag)
        else $error("overflow not cleared in trap");

    a_trap_save: assert property (
        phase_r == PH7 && bt_r == BT_T24 && prog_operator_flag && !timeshare_active
        |=> mem_wdata == $past(c_r) && !prog_operator_flag)
        else $error("saved word not moved to memory data");

endmodule // serial_address_modifier

// >>> test/mem_partner.sv
// core memory and execution sequencer model facing the address modifier
`timescale 1ns/10ps

module mem_partner (
    input  wire logic        clock,
    input  wire logic [4:0]  bit_time,
    input  wire logic [2:0]  phase,
    input  wire logic [13:0] mem_addr,
    input  wire logic [23:0] mem_wdata,
    input  wire logic        mem_cycle_start,
    input  wire logic        go_on,
    input  wire logic [13:0] index_value,
    output logic [23:0]      mem_rdata,
    output logic             exec_done,
    output logic             index_serial
);
    import addr_mod_pkg::*;

    logic [23:0] mem [0:16383];
    logic        wr_pend;
    logic [4:0]  idx_pos;

    // cleared core so that fetches never load unknown words
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 24'h000000;
        end
        wr_pend = 1'b0;
    end

    // sense data settle only late in the cycle; earlier the lines toggle so an early sample shows
    assign mem_rdata = (bit_time <= BT_T0) ? mem[mem_addr] : {12{bit_time[0], ~bit_time[0]}};
    // index register recirculates lsb first from T23 on; outside the field the line keeps moving
    assign idx_pos      = BT_T23 - bit_time;
    assign index_serial = (idx_pos < 5'h0E) ? index_value[idx_pos[3:0]] : bit_time[0];
    // execution ends only when the bench allows, so phase one can be stretched at will
    assign exec_done    = go_on && (phase == PH1) && (bit_time == BT_TP);

    // the write half of the core cycle lands mid-cycle, well after the data register is loaded
    always @(posedge clock) begin
        if (mem_cycle_start) begin
            wr_pend <= 1'b1;
        end else if (wr_pend && bit_time == BT_T10) begin
            mem[mem_addr] <= mem_wdata;
            wr_pend       <= 1'b0;
        end
    end
endmodule // mem_partner

// >>> test/tb.sv
// self-checking bench for the serial address modifier
`timescale 1ns/10ps

module tb;
    import addr_mod_pkg::*;

    logic        clock, rst_n, overflow_set, go_on, exec_done, index_serial, mem_cycle_start, add_sum, re_seen;
    logic        sco;
    bus_req_s    req;
    logic [31:0] rdata, seed, r;
    logic [13:0] index_value, mem_addr, a, x, b, c, s, p;
    logic [23:0] mem_rdata, mem_wdata;
    logic [4:0]  bit_time;
    logic [2:0]  phase;
    logic [5:0]  op_code, op;
    logic [5:0]  brs [3] = '{OP_BRU, OP_BRX, OP_BRM};
    logic [63:0] qe;
    logic [63:0] rd_q [$];
    logic [37:0] wr_q [$];
    int          miscompares, n_tests;

    initial clock = 1'b0;
    always #5 clock = ~clock;

    serial_address_modifier dut_u (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
        .timeshare_active(1'b0), .index_serial(index_serial), .single_cycle_op(sco), .exec_done(exec_done),
        .overflow_set(overflow_set), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_cycle_start(mem_cycle_start), .bit_time(bit_time), .phase(phase), .op_code(op_code),
        .add_sum(add_sum));
    mem_partner pt_u (.clock(clock), .bit_time(bit_time), .phase(phase), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_cycle_start(mem_cycle_start), .go_on(go_on), .index_value(index_value),
        .mem_rdata(mem_rdata), .exec_done(exec_done), .index_serial(index_serial));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_wr(input logic [37:0] got, input logic [37:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // every access takes two cycles so no strobe is assigned twice in one time step
    task automatic wr(input logic [4:0] ad, input logic [31:0] d);
        req <= '{addr: ad, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clock);
        req <= '{addr: ad, wdata: d, we: 1'b0, re: 1'b0};
        @(posedge clock);
    endtask

    task automatic rd(input logic [4:0] ad, input logic [31:0] m, input logic [31:0] e);
        rd_q.push_back({m, e});
        req <= '{addr: ad, wdata: 32'h00000000, we: 1'b0, re: 1'b1};
        @(posedge clock);
        req <= '{addr: ad, wdata: 32'h00000000, we: 1'b0, re: 1'b0};
        @(posedge clock);
    endtask

    task automatic wait_ph(input logic [2:0] ph, input logic [4:0] bt);
        int k;
        k = 0;
        while (!(phase === ph && bit_time === bt) && k < 400) begin
            @(posedge clock);
            k++;
        end
        if (k >= 400) begin
            miscompares++;
            $display("wrong value at %0t: phase %h expected %h", $time, phase, ph);
        end
    endtask

    // the word is written in the final bit of a phase one that go_on lets end, so it overrides the memory reload
    // and stands whole at T24; run is dropped once the instruction has been taken
    task automatic run_instr(input logic [23:0] w, input logic [2:0] ph);
        wait_ph(PH1, BT_T24);
        wr(OFF_CTRL, 32'h00000001);
        go_on <= 1'b1;
        wait_ph(PH1, BT_T0);
        wr(OFF_INSTR, {8'h00, w});
        go_on <= 1'b0;
        wait_ph(ph, BT_T24);
        wr(OFF_CTRL, 32'h00000000);
    endtask

    task automatic settle();
        go_on <= 1'b1;
        repeat (60) @(posedge clock);
        go_on <= 1'b0;
        @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // read answers stand only in the cycle after the strobe; the trap save is seen mid phase seven
    always @(posedge clock) begin
        if (re_seen) begin
            qe = rd_q.pop_front();
            cmp_rd(rdata & qe[63:32], qe[31:0]);
        end
        re_seen = req.re;
        if (rst_n === 1'b1 && phase === PH7 && bit_time === BT_T10) begin
            cmp_wr({mem_addr, mem_wdata}, wr_q.pop_front());
        end
    end

    // a hang is cut short well beyond the few thousand cycles the run needs
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end

    initial begin
        req = '0; rst_n = 1'b0; overflow_set = 1'b0; go_on = 1'b0; index_value = 14'h0000; sco = 1'b0;
        seed = 32'h000096E4; miscompares = 0; n_tests = 0; re_seen = 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        wr(OFF_STATUS, 32'hFFFFFFFF);
        rd(OFF_STATUS, 32'hFFFFFFFF, 32'h00001000);
        rd(OFF_PC, 32'hFFFFFFFF, 32'h00000000);
        rd(5'h14, 32'hFFFFFFFF, 32'h00000000);
        // plain and indexed instructions, address field modified only
        for (int i = 0; i < 4; i++) begin
            r = rnd(); a = r[13:0]; x = r[27:14]; op = {2'b11, r[31:28]};
            index_value <= x;
            s = a + (i[0] ? x : 14'h0000);
            run_instr({1'b0, i[0], 1'b0, op, 1'b0, a}, PH0);
            wait_ph(PH1, BT_T10);
            rd(OFF_ADDR, 32'h00003FFF, {18'h0, s});
            rd(OFF_INSTR, 32'h00FFFFFF, {9'h0, i[0], 1'b0, op, 1'b0, s});
            rd(OFF_STATUS, 32'h00003F7F, {18'h0, op, 8'h01});
            settle();
        end
        // each branch code shifts the indexed sum into the counter
        for (int j = 0; j < 3; j++) begin
            r = rnd(); a = r[13:0]; x = r[27:14];
            index_value <= x;
            s = a + x;
            run_instr({1'b0, 1'b1, 1'b0, brs[j], 1'b0, a}, PH0);
            repeat (30) @(posedge clock);
            rd(OFF_PC, 32'h00003FFF, {18'h0, s});
            settle();
        end
        // two-level indirect chain, indexed on the second and third words
        r = rnd(); a = r[13:0]; x = r[27:14]; r = rnd(); b = r[13:0]; c = r[27:14]; op = 6'h35;
        index_value <= x;
        s = c + x;
        pt_u.mem[a] = {1'b0, 1'b1, 1'b0, 6'h07, 1'b1, c};
        pt_u.mem[s] = {1'b0, 1'b1, 1'b0, 6'h07, 1'b0, b};
        s = b + x;
        run_instr({3'h0, op, 1'b1, a}, PH1);
        rd(OFF_ADDR, 32'h00003FFF, {18'h0, s});
        rd(OFF_INSTR, 32'h00FFFFFF, {9'h0, 1'b1, 1'b0, 6'h07, 1'b0, s});
        rd(OFF_STATUS, 32'h00003F7F, {18'h0, op, 8'h01});
        settle();
        // program operator trap with and without a pending overflow
        for (int i = 0; i < 2; i++) begin
            r = rnd(); p = r[13:0]; op = r[19:14];
            overflow_set <= i[0];
            @(posedge clock);
            overflow_set <= 1'b0;
            wr(OFF_PC, {18'h0, p});
            wr_q.push_back({14'h0000, i[0], 8'h00, 1'b1, p});
            run_instr({3'h1, op, 1'b0, r[27:14]}, PH0);
            wait_ph(PH7, BT_T10);
            rd(OFF_PC, 32'h00003FFF, {25'h0000001, op});
            rd(OFF_ADDR, 32'h00003FFF, {25'h0000001, op});
            rd(OFF_STATUS, 32'h00003F7F, {18'h0, OP_NOP, 8'h07});
            settle();
        end
        // single-cycle opcode: the indirect bit fetches nothing, flag is left set
        r = rnd(); a = r[13:0]; op = {2'b11, r[19:16]};
        sco <= 1'b1;
        run_instr({3'h0, op, 1'b1, a}, PH1);
        sco <= 1'b0;
        rd(OFF_ADDR, 32'h00003FFF, {18'h0, a});
        rd(OFF_STATUS, 32'h00003F7F, {18'h0, op, 8'h11});
        repeat (4) @(posedge clock);
        end_of_test();
    end
endmodule // tb
